// ### io_seq_pkg.sv
`default_nettype none
package io_seq_pkg;

  // clock and timing
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int STROBE_TIME_PS = 247500;
  // longest time, so the division rounds down
  localparam int STROBE_CYCLES  = STROBE_TIME_PS / CLK_PERIOD_PS;
  localparam int STROBE_CNT_W   = 7;
  localparam logic [STROBE_CNT_W-1:0] STROBE_LOAD =
    STROBE_CNT_W'(STROBE_CYCLES);
  localparam logic [STROBE_CNT_W-1:0] STROBE_LAST = 7'h01;

  // one microinstruction lasts this many clocks
  localparam int MICRO_DIV = 4;
  localparam logic [1:0] MICRO_LAST = 2'(MICRO_DIV - 1);

  // control buffer field positions
  localparam int CB_SRC_LO = 0;
  localparam int CB_DONE   = 3;
  localparam int CB_OP_LO  = 4;
  localparam int CB_BUS_EN = 6;
  localparam int CB_BUSY   = 7;
  localparam int CB_FRY    = 8;
  localparam int CB_DRY    = 9;

  // register input source select
  localparam logic [1:0] SRC_ALU  = 2'h0;
  localparam logic [1:0] SRC_MEM  = 2'h1;
  localparam logic [1:0] SRC_SWAP = 2'h2;
  localparam logic [1:0] SRC_BUS  = 2'h3;

  // register operation select
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_SHR  = 2'h1;
  localparam logic [1:0] OP_SHL  = 2'h2;
  localparam logic [1:0] OP_LOAD = 2'h3;

  // sequence addresses and control store words
  localparam logic [7:0]  SEQ_INPUT_START = 8'h0C;
  localparam logic [7:0]  SEQ_NOP_A       = 8'h0D;
  localparam logic [7:0]  SEQ_NOP_B       = 8'h0E;
  localparam logic [7:0]  SEQ_FRY_A       = 8'h0F;
  localparam logic [7:0]  SEQ_FRY_B       = 8'h10;
  localparam logic [7:0]  SEQ_SEL_BUS     = 8'h11;
  localparam logic [7:0]  SEQ_DRY         = 8'h12;
  localparam logic [7:0]  SEQ_LATCH       = 8'h13;
  localparam logic [7:0]  SEQ_END         = 8'h14;
  localparam logic [7:0]  SEQ_PARK        = 8'h15;
  localparam logic [15:0] CB_IDLE_CODE    = 16'h0000;
  localparam logic [15:0] CB_BUSY_CODE    = 16'h0088;
  localparam logic [15:0] W_LOAD_ALU      = 16'h00F8;
  localparam logic [15:0] W_DRIVE         = 16'h00C8;
  localparam logic [15:0] W_DRIVE_FRY     = 16'h01C8;
  localparam logic [15:0] W_SEL_BUS       = 16'h008B;
  localparam logic [15:0] W_SEL_DRY       = 16'h028B;
  localparam logic [15:0] W_LATCH_DONE    = 16'h02B3;

  // central control constants
  localparam logic [15:0] INPUT_MASK    = 16'h2000;
  localparam logic [15:0] IR_FIELD_MASK = 16'h01FF;
  localparam logic [15:0] PC_STEP       = 16'h0001;

  // APB register map
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_INSTR  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ACC    = 8'h0C;
  localparam logic [7:0] REG_IOREG  = 8'h10;
  localparam logic [7:0] REG_PC     = 8'h14;
  localparam logic [7:0] REG_EREG   = 8'h18;
  localparam int CMD_START_BIT = 0;

  typedef enum logic [2:0]
  {
    CPU_IDLE,
    CPU_MASK_LOAD,
    CPU_REQUEST,
    CPU_FORM,
    CPU_WAIT_DONE,
    CPU_MOVE,
    CPU_DECODE
  } cpu_state_type;

endpackage : io_seq_pkg
`default_nettype wire

// ### io_strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none
module io_strobe_timer
  import io_seq_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic start,
  // strobe and its end mark
  output logic      strobe,
  output logic      strobe_end_timing
);

  typedef struct packed
  {
    logic                    active;
    logic                    ended;
    logic [STROBE_CNT_W-1:0] count;
  } timer_state_type;

  timer_state_type q;
  timer_state_type d;

  always_comb
  begin
    d = q;
    d.ended = 1'b0;
    if (start)
    begin
      // a new start restarts the full width
      d.active = 1'b1;
      d.count  = STROBE_LOAD;
    end
    else if (q.active)
    begin
      if (q.count == STROBE_LAST)
      begin
        d.active = 1'b0;
        d.ended  = 1'b1;
      end
      d.count = q.count - STROBE_LAST;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign strobe            = q.active;
  assign strobe_end_timing = q.ended;

endmodule : io_strobe_timer
`default_nettype wire

// ### io_control_store.sv
`timescale 1ns/1ps
`default_nettype none
module io_control_store
  import io_seq_pkg::*;
(
  // address and word
  input  wire logic [7:0]  addr,
  output logic      [15:0] word
);

  function automatic logic [15:0] store_word(input logic [7:0] a);
    case (a)
      8'h00:           store_word = CB_BUSY_CODE;
      SEQ_INPUT_START: store_word = W_LOAD_ALU;
      SEQ_NOP_A:       store_word = W_DRIVE;
      SEQ_NOP_B:       store_word = W_DRIVE;
      SEQ_FRY_A:       store_word = W_DRIVE_FRY;
      SEQ_FRY_B:       store_word = W_DRIVE_FRY;
      SEQ_SEL_BUS:     store_word = W_SEL_BUS;
      SEQ_DRY:         store_word = W_SEL_DRY;
      SEQ_LATCH:       store_word = W_LATCH_DONE;
      SEQ_END:         store_word = CB_IDLE_CODE;
      SEQ_PARK:        store_word = CB_BUSY_CODE;
      // unused locations end any stray sequence
      default:         store_word = CB_IDLE_CODE;
    endcase
  endfunction : store_word

  assign word = store_word(addr);

endmodule : io_control_store
`default_nettype wire

// ### io_input_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module io_input_sequencer
  import io_seq_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // parallel I/O bus
  input  wire logic [15:0] io_bus_in,
  output logic      [15:0] io_bus_out,
  output logic             io_bus_oe,
  output logic             function_ready_strobe,
  output logic             data_ready_strobe
);
  import io_seq_pkg::*;

  typedef struct packed
  {
    cpu_state_type cpu;
    logic          start_req;
    logic [15:0]   ir;
    logic [15:0]   operand;
    logic [15:0]   e_reg;
    logic [15:0]   alu;
    logic [15:0]   acc;
    logic [15:0]   pc;
    logic [15:0]   ioreg;
    logic [15:0]   cbuf;
    logic [7:0]    seq_addr;
    logic [1:0]    div;
    logic          micro_en;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          bus_oe;
  } seq_state_type;

  // all state but the two strobe timers' in one bank; every output leaves a flop
  seq_state_type q;
  seq_state_type d;

  logic [15:0] rom_word;
  logic        fry_start;
  logic        dry_start;
  logic        fry_strobe;
  logic        dry_strobe;

  function automatic logic [15:0] byte_swap(input logic [15:0] w);
    byte_swap = {w[7:0], w[15:8]};
  endfunction : byte_swap

  // misaligned or unknown offsets answer with an error
  function automatic logic reg_mapped(input logic [7:0] a);
    case (a)
      REG_CMD, REG_INSTR, REG_STATUS, REG_ACC,
      REG_IOREG, REG_PC, REG_EREG: reg_mapped = 1'b1;
      default:                     reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  // store reads without a clock from the registered address
  io_control_store u_store
  (
    .addr (q.seq_addr),
    .word (rom_word)
  );

  // strobes begin on the microinstruction edge that ends their step
  assign fry_start = q.micro_en & q.cbuf[CB_BUSY] & q.cbuf[CB_FRY];
  assign dry_start = q.micro_en & q.cbuf[CB_BUSY] & q.cbuf[CB_DRY];

  // end marks go unused: each timer stops its own strobe
  io_strobe_timer u_fry_timer
  (
    .clk               (clk),
    .rst_n             (rst_n),
    .start             (fry_start),
    .strobe            (fry_strobe),
    .strobe_end_timing ()
  );

  io_strobe_timer u_dry_timer
  (
    .clk               (clk),
    .rst_n             (rst_n),
    .start             (dry_start),
    .strobe            (dry_strobe),
    .strobe_end_timing ()
  );

  always_comb
  begin
    logic        setup;
    logic        access;
    logic        seq_busy;
    logic        accept;
    logic [15:0] reg_src;
    setup    = 1'b0;
    access   = 1'b0;
    seq_busy = 1'b0;
    accept   = 1'b0;
    reg_src  = 16'h0000;
    d = q;

    // microinstruction rate enable
    d.micro_en = (q.div == MICRO_LAST);
    if (q.div == MICRO_LAST)
      d.div = 2'h0;
    else
      d.div = q.div + 2'h1;

    // APB: one wait-free access phase per transfer
    setup  = psel & ~penable;
    access = psel & penable & q.pready;
    d.pready = setup;
    // read data is taken at setup and stands in the access cycle
    if (setup)
    begin
      d.pslverr = ~reg_mapped(paddr);
      case (paddr)
        REG_INSTR:  d.prdata = {16'h0000, q.ir};
        // control bits low, sequence address and cpu state above
        REG_STATUS: d.prdata = {8'h00, 5'h00, q.cpu, q.seq_addr,
                                3'h0, dry_strobe, fry_strobe,
                                (q.cpu != CPU_IDLE),
                                q.cbuf[CB_DONE], q.cbuf[CB_BUSY]};
        REG_ACC:    d.prdata = {16'h0000, q.acc};
        REG_IOREG:  d.prdata = {16'h0000, q.ioreg};
        REG_PC:     d.prdata = {16'h0000, q.pc};
        REG_EREG:   d.prdata = {16'h0000, q.e_reg};
        default:    d.prdata = 32'h0000_0000;
      endcase
    end
    // writes land only at the edge that completes the access
    if (access && pwrite)
    begin
      case (paddr)
        REG_CMD:
        begin
          // a start while an instruction runs is ignored
          if (pwdata[CMD_START_BIT] && q.cpu == CPU_IDLE)
            d.start_req = 1'b1;
        end
        REG_INSTR: d.ir = pwdata[15:0];
        REG_PC:    d.pc = pwdata[15:0];
        default:   d.ir = d.ir;
      endcase
    end

    // the buffer's busy bit gates the counter and the register
    seq_busy = q.cbuf[CB_BUSY];

    if (q.micro_en)
    begin
      // central control
      case (q.cpu)
        CPU_IDLE:
        begin
          if (q.start_req)
          begin
            d.start_req = 1'b0;
            d.cpu       = CPU_MASK_LOAD;
          end
        end
        CPU_MASK_LOAD:
        begin
          d.operand = INPUT_MASK;
          d.cpu     = CPU_REQUEST;
        end
        CPU_REQUEST:
        begin
          if (!seq_busy)
          begin
            accept  = 1'b1;
            d.e_reg = q.operand;
            d.cpu   = CPU_FORM;
          end
          // otherwise the request step repeats
        end
        CPU_FORM:
        begin
          d.alu = q.e_reg | (q.ir & IR_FIELD_MASK);
          d.cpu = CPU_WAIT_DONE;
        end
        // done bit drops at the latch step, while the sequence still runs
        CPU_WAIT_DONE:
        begin
          if (!(seq_busy && q.cbuf[CB_DONE]))
            d.cpu = CPU_MOVE;
        end
        CPU_MOVE:
        begin
          // overlaps the sequencer's idle step
          d.acc = q.ioreg;
          d.pc  = q.pc + PC_STEP;
          d.cpu = CPU_DECODE;
        end
        CPU_DECODE:
        begin
          d.cpu = CPU_IDLE;
        end
        default:
        begin
          d.cpu = CPU_IDLE;
        end
      endcase

      // sequencer address counter and control buffer
      if (accept)
      begin
        // buffer takes the word at the parked address
        d.seq_addr = SEQ_INPUT_START;
        d.cbuf     = rom_word;
      end
      else if (seq_busy)
      begin
        // steps run 0C..14 in order
        d.cbuf     = rom_word;
        d.seq_addr = q.seq_addr + 8'h01;
      end

      // I/O register input source
      case (q.cbuf[CB_SRC_LO +: 2])
        SRC_ALU:  reg_src = q.alu;
        SRC_MEM:  reg_src = 16'h0000;
        // the input sequence never picks the swapped bus
        SRC_SWAP: reg_src = byte_swap(io_bus_in);
        SRC_BUS:  reg_src = io_bus_in;
        default:  reg_src = 16'h0000;
      endcase

      if (!seq_busy)
      begin
        // idle: follows the ALU without a command
        d.ioreg = q.alu;
      end
      else
      begin
        case (q.cbuf[CB_OP_LO +: 2])
          OP_LOAD: d.ioreg = reg_src;
          OP_SHR:  d.ioreg = {8'h00, q.ioreg[15:8]};
          OP_SHL:  d.ioreg = {q.ioreg[7:0], 8'h00};
          OP_NONE: d.ioreg = q.ioreg;
          default: d.ioreg = q.ioreg;
        endcase
      end
    end

    // a flop of its own, so the enable never leaves a gate
    d.bus_oe = d.cbuf[CB_BUS_EN] & d.cbuf[CB_BUSY];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  // all outputs are state flops
  assign prdata                = q.prdata;
  assign pready                = q.pready;
  assign pslverr               = q.pslverr;
  assign io_bus_out            = q.ioreg;
  assign io_bus_oe             = q.bus_oe;
  // a restart at step 10 stretches the strobe, never chops it
  assign function_ready_strobe = fry_strobe;
  assign data_ready_strobe     = dry_strobe;

endmodule : io_input_sequencer
`default_nettype wire

// ### io_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module io_seq_props
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // parallel bus
  input wire logic [15:0] io_bus_in,
  input wire logic [15:0] io_bus_out,
  input wire logic        io_bus_oe,
  input wire logic        function_ready_strobe,
  input wire logic        data_ready_strobe
);
  // run length of the function strobe, restart included
  logic [6:0] fcnt_q;
  logic [6:0] fcnt_d;
  always_comb
  begin
    fcnt_d = function_ready_strobe ? fcnt_q + 7'h01 : 7'h00;
  end
  always_ff @(posedge clk)
  begin
    fcnt_q <= rst_n ? fcnt_d : 7'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("answer held too long");
  AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h18
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  AST_FRY_DRIVE: assert property ($rose(function_ready_strobe) |->
    io_bus_oe && $past(io_bus_oe, 4)) else $error("strobe without bus");
  AST_SETTLE: assert property ($rose(function_ready_strobe) |->
    ##3 io_bus_oe ##1 !io_bus_oe) else $error("settling step wrong");
  AST_DRY_SEL: assert property ($rose(data_ready_strobe) |->
    !io_bus_oe && !$past(io_bus_oe, 4)) else $error("bus not selected");
  AST_LATCH: assert property ($rose(data_ready_strobe) |->
    ##4 io_bus_out == $past(io_bus_in)) else $error("bus word not latched");
  AST_FRY_LEN: assert property ($fell(function_ready_strobe) |->
    fcnt_q inside {[61:65]}) else $error("function strobe length");
  AST_DRY_LEN: assert property ($fell(data_ready_strobe) |->
    $past(data_ready_strobe, 61)) else $error("data strobe too short");
endmodule : io_seq_props
`default_nettype wire

// ### io_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module io_dev_model
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // behaviour
  input  wire logic        slow,
  input  wire logic [15:0] word,
  // bus
  input  wire logic [15:0] io_bus_out,
  input  wire logic        io_bus_oe,
  input  wire logic        fry,
  input  wire logic        dry,
  output logic      [15:0] io_bus_in,
  output logic      [15:0] cmd_q
);
  logic sel_q;
  logic fry_q;
  always_ff @(posedge clk)
  begin
    fry_q <= fry;
    if (!rst_n)
    begin
      sel_q <= 1'b0;
      cmd_q <= 16'h0000;
    end
    else if (fry && !fry_q)
    begin
      sel_q <= 1'b1;
      cmd_q <= io_bus_out;
    end
    else if (!dry && sel_q && io_bus_oe === 1'b0 && fry === 1'b0)
      sel_q <= 1'b0;
    // released bus keeps toggling so stale data never looks valid
    if (!rst_n)
      io_bus_in <= 16'h0000;
    else if (sel_q && !io_bus_oe && (!slow || dry))
      io_bus_in <= word;
    else
      io_bus_in <= ~io_bus_in;
  end
endmodule : io_dev_model
`default_nettype wire

// ### io_input_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module io_input_sequencer_tb;
  import io_seq_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] bus_in;
  logic [15:0] bus_out;
  logic        bus_oe;
  logic        fn_ready;
  logic        data_ready;
  logic        slow;
  logic [15:0] word;
  logic [15:0] cmd;
  int          fails;
  int          cmp_count;
  io_input_sequencer i_io_input_sequencer (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_bus_in(bus_in), .io_bus_out(bus_out), .io_bus_oe(bus_oe),
    .function_ready_strobe(fn_ready), .data_ready_strobe(data_ready));
  io_dev_model i_io_dev_model (.clk(clk), .rst_n(rst_n), .slow(slow),
    .word(word), .io_bus_out(bus_out), .io_bus_oe(bus_oe), .fry(fn_ready),
    .dry(data_ready), .io_bus_in(bus_in), .cmd_q(cmd));
  always #2 clk = ~clk;
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    check(32'({bus_oe, fn_ready, data_ready}), 32'h0);
    apb(REG_STATUS, 1'b0, 32'h0, r, e);
    check(r, 32'h0);
    apb(REG_ACC, 1'b1, 32'hFFFF, r, e);
    apb(REG_ACC, 1'b0, 32'h0, r, e);
    check(r, 32'h0);
    apb(8'h1C, 1'b0, 32'h0, r, e);
    check(32'(e), 32'h1);
  endtask : t_reset
  // one input instruction; a second start while it runs must be ignored
  task automatic t_input(input logic [15:0] ir, input logic [15:0] w,
    input logic s);
    logic [31:0] r;
    logic        e;
    logic        busy;
    logic        waited;
    int          n;
    logic [31:0] x;
    busy = 1'b0;
    waited = 1'b0;
    slow <= s;
    word <= w;
    apb(REG_INSTR, 1'b1, {16'h0000, ir}, r, e);
    apb(REG_PC, 1'b1, 32'h1234, r, e);
    apb(REG_CMD, 1'b1, 32'h1, r, e);
    for (n = 0; n < 100 && !(busy && r[2] === 1'b0); n++)
    begin
      apb(REG_STATUS, 1'b0, 32'h0, r, e);
      if (r[18:16] === 3'h4)
        waited = 1'b1;
      if (r[0] === 1'b1 && !busy)
      begin
        busy = 1'b1;
        check(32'(r[1:0]), 32'h3);
        apb(REG_CMD, 1'b1, 32'h1, x, e);
      end
    end
    if (n == 100)
    begin
      fails++;
      tally_and_finish();
    end
    check(32'(waited), 32'h1);
    apb(REG_ACC, 1'b0, 32'h0, r, e);
    check(r, {16'h0000, w});
    apb(REG_PC, 1'b0, 32'h0, r, e);
    check(r, 32'h1235);
    apb(REG_EREG, 1'b0, 32'h0, r, e);
    check(r, 32'h2000);
    check(32'(cmd), 32'(16'h2000 | (ir & 16'h01FF)));
    apb(REG_STATUS, 1'b0, 32'h0, r, e);
    check(32'({r[15:8], r[2], r[0]}), 32'h54);
  endtask : t_input
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    word = 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_input(16'hFFFF, 16'hA5C3, 1'b0);
    t_input(16'h0000, 16'h5A3C, 1'b1);
    t_input(16'h0155, 16'hFFFF, 1'b0);
    tally_and_finish();
  end
endmodule : io_input_sequencer_tb
bind io_input_sequencer io_seq_props i_io_seq_props (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .io_bus_in(io_bus_in), .io_bus_out(io_bus_out), .io_bus_oe(io_bus_oe),
  .function_ready_strobe(function_ready_strobe),
  .data_ready_strobe(data_ready_strobe));
`default_nettype wire
